// [design/tpc_pins_regs.svh]
// Purpose: constants of the transceiver host pin logic
// Assumes: 20 MHz system clock
// Notes: times in their own unit, cycle counts derived
// Operation
// - indicator select high puts checksum-valid indication on aux_pin_2.
// - indicator select high puts out-of-idle indication on aux_pin_1.
// - reset pin low holds off mode and loses all programmed settings.
// - reset pin release enters idle with every setting at default.
// - sequence trigger rising edge starts receive or transmit per programmed choice.
// - sequence trigger low forces idle and stops receive or transmit.
// - wake input low moves hibernate or doze into idle.
// - clock output selectable among eight rates, 16 MHz down to 16.393 kHz; here the 16 and 8 MHz settings give 10 MHz and 4 MHz gives 5 MHz.
// - clock output runs at the 32.786 kHz setting after reset.
// - interrupt output active low, open drain, pull-up enable programmable.
// - interrupts may be serviced as often as every 6 microseconds.
// - serial transfers accepted only while chip select is low.
// - all seven aux pins come out of reset as inputs.
// - serial output floats when deselected unless float enable cleared, then low.
// - first byte of a transaction is header with 6-bit address and direction.
// - serial data sampled on rising clock edge, output changes on falling.
`ifndef TPC_PINS_REGS_SVH
`define TPC_PINS_REGS_SVH

`define TPC_SYS_CLK_HZ 20000000
`define TPC_IRQ_SERVICE_NS 6000
`define TPC_IRQ_SERVICE_CYC ((`TPC_IRQ_SERVICE_NS * (`TPC_SYS_CLK_HZ / 1000000)) / 1000)
`define TPC_IRQ_GAP_CYC 2
`define TPC_RATE_16M_HZ 16000000
`define TPC_RATE_8M_HZ 8000000
`define TPC_RATE_4M_HZ 4000000
`define TPC_RATE_2M_HZ 2000000
`define TPC_RATE_1M_HZ 1000000
`define TPC_RATE_62K5_HZ 62500
`define TPC_RATE_32K7_HZ 32786
`define TPC_RATE_16K3_HZ 16393
`define TPC_RATE_SEL_RST 3'h6
`define TPC_RATE_SEL_DOZE_MAX 3'h4
`define TPC_HDR_RW_BIT 7
`define TPC_HDR_ADDR_MSB 5
`define TPC_AUX_COUNT 7
`define TPC_AUX_DIR_RST 7'h00
`define TPC_AUX_OUT_RST 7'h00
`define TPC_ALT_EN_RST 1'b0
`define TPC_PULLUP_RST 1'b1
`define TPC_MISO_HIZ_RST 1'b1
`define TPC_DOZE_CLK_RST 1'b0
`define TPC_SEQ_TX_RST 1'b0

`endif

// [design/tpc_pins_pkg.sv]
// Purpose: types of the transceiver host pin logic
// Assumes: constants live in tpc_pins_regs.svh
// Notes: none
package tpc_pins_pkg;

  typedef enum logic [5:0] {
    TPC_OFF = 6'b00_0001,
    TPC_IDLE = 6'b00_0010,
    TPC_HIBERNATE = 6'b00_0100,
    TPC_DOZE = 6'b00_1000,
    TPC_RX = 6'b01_0000,
    TPC_TX = 6'b10_0000
  } tpc_mode_type;

  typedef struct packed {
    logic alt_en;
    logic [2:0] rate_sel;
    logic pullup_en;
    logic miso_hiz_en;
    logic doze_clk_en;
    logic seq_tx;
    logic [6:0] aux_dir;
    logic [6:0] aux_out;
  } tpc_cfg_type;

  typedef struct packed {
    logic rd;
    logic [5:0] addr;
    logic [7:0] data;
  } tpc_spi_word_type;

endpackage

// [design/tpc_pin_ctrl.sv]
// Purpose: host-facing pin logic of a packet radio transceiver
// Assumes: pins and serial clock arrive asynchronously; serial clock well below sys_clk/4
// Notes: 16 MHz clock output is limited to sys_clk/2 by the 20 MHz core clock
`include "tpc_pins_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic radio_sequence_trigger,
  input wire logic wake_request_n,
  input wire logic hibernate_req,
  input wire logic doze_req,
  input wire logic cfg_wr,
  input wire tpc_pins_pkg::tpc_cfg_type cfg_in,
  output tpc_pins_pkg::tpc_cfg_type cfg_q,
  output tpc_pins_pkg::tpc_mode_type mode_q,
  input wire logic crc_valid,
  input wire logic irq_event,
  input wire logic irq_ack,
  output logic irq_n_o,
  output logic irq_n_oe,
  output logic irq_pullup_en,
  output logic host_clock_out,
  output logic host_clock_oe,
  input wire logic serial_clock_in,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  output logic spi_valid,
  output tpc_pins_pkg::tpc_spi_word_type spi_word_q,
  input wire logic [7:0] spi_rd_byte,
  input wire logic [6:0] aux_pin_i,
  output logic [6:0] aux_pin_o,
  output logic [6:0] aux_pin_oe,
  output logic [6:0] aux_in_q
);

  // half period of the clock output in sys_clk cycles, never below one
  function automatic logic [9:0] half_cycles(input logic [2:0] sel);
    int hz;
    int h;
    case (sel)
      3'h0: hz = `TPC_RATE_16M_HZ;
      3'h1: hz = `TPC_RATE_8M_HZ;
      3'h2: hz = `TPC_RATE_4M_HZ;
      3'h3: hz = `TPC_RATE_2M_HZ;
      3'h4: hz = `TPC_RATE_1M_HZ;
      3'h5: hz = `TPC_RATE_62K5_HZ;
      3'h6: hz = `TPC_RATE_32K7_HZ;
      default: hz = `TPC_RATE_16K3_HZ;
    endcase
    h = `TPC_SYS_CLK_HZ / (2 * hz);
    if (h < 1) begin
      h = 1;
    end
    return h[9:0];
  endfunction

  localparam tpc_pins_pkg::tpc_cfg_type CFG_RST = '{
    alt_en: `TPC_ALT_EN_RST, rate_sel: `TPC_RATE_SEL_RST, pullup_en: `TPC_PULLUP_RST,
    miso_hiz_en: `TPC_MISO_HIZ_RST, doze_clk_en: `TPC_DOZE_CLK_RST, seq_tx: `TPC_SEQ_TX_RST,
    aux_dir: `TPC_AUX_DIR_RST, aux_out: `TPC_AUX_OUT_RST};

  // two-flop synchronisers; stage one is read only by stage two
  logic [12:0] sync1_q;
  logic [12:0] sync2_q;
  logic sclk_prev_q;
  logic trig_prev_q;
  logic crc_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_q <= 13'h0013; // idle pin levels: no false select or wake after reset
      sync2_q <= 13'h0013;
      sclk_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
      crc_q <= 1'b0;
    end else begin
      sync1_q <= {aux_pin_i, serial_clock_in, chip_select_n, mosi,
        radio_sequence_trigger, wake_request_n, reset_pin_n};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[5];
      trig_prev_q <= sync2_q[2];
      crc_q <= crc_valid;
    end
  end

  logic rst_pin_s, wake_s, trig_s, mosi_s, cs_s, sclk_rise, sclk_fall, off;
  assign rst_pin_s = sync2_q[0];
  assign wake_s = sync2_q[1];
  assign trig_s = sync2_q[2];
  assign mosi_s = sync2_q[3];
  assign cs_s = ~sync2_q[4];
  assign sclk_rise = sync2_q[5] & ~sclk_prev_q;
  assign sclk_fall = ~sync2_q[5] & sclk_prev_q;
  assign off = mode_q == tpc_pins_pkg::TPC_OFF;

  // settings and mode
  tpc_pins_pkg::tpc_cfg_type cfg_d;
  tpc_pins_pkg::tpc_mode_type mode_d;
  always_comb begin
    cfg_d = cfg_q;
    mode_d = mode_q;
    if (!rst_pin_s) begin
      cfg_d = CFG_RST;
      mode_d = tpc_pins_pkg::TPC_OFF;
    end else begin
      if (cfg_wr && !off) begin
        cfg_d = cfg_in;
      end
      case (mode_q)
        tpc_pins_pkg::TPC_OFF: mode_d = tpc_pins_pkg::TPC_IDLE;
        tpc_pins_pkg::TPC_IDLE: begin
          if (trig_s && !trig_prev_q) begin
            mode_d = cfg_q.seq_tx ? tpc_pins_pkg::TPC_TX : tpc_pins_pkg::TPC_RX;
          end else if (hibernate_req) begin
            mode_d = tpc_pins_pkg::TPC_HIBERNATE;
          end else if (doze_req) begin
            mode_d = tpc_pins_pkg::TPC_DOZE;
          end
        end
        tpc_pins_pkg::TPC_HIBERNATE, tpc_pins_pkg::TPC_DOZE: begin
          if (!wake_s) begin
            mode_d = tpc_pins_pkg::TPC_IDLE;
          end
        end
        tpc_pins_pkg::TPC_RX, tpc_pins_pkg::TPC_TX: begin
          // sequence ends only when the host drops the trigger or pulls the reset pin low
          if (!trig_s) begin
            mode_d = tpc_pins_pkg::TPC_IDLE;
          end
        end
        default: mode_d = tpc_pins_pkg::TPC_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= CFG_RST;
      mode_q <= tpc_pins_pkg::TPC_OFF;
    end else begin
      cfg_q <= cfg_d;
      mode_q <= mode_d;
    end
  end

  // clock output divider
  logic [9:0] div_q, div_d;
  logic host_clock_out_q, host_clock_out_d, host_clock_out_run;
  always_comb begin
    host_clock_out_run = mode_q == tpc_pins_pkg::TPC_IDLE || mode_q == tpc_pins_pkg::TPC_RX
      || mode_q == tpc_pins_pkg::TPC_TX
      || (mode_q == tpc_pins_pkg::TPC_DOZE && cfg_q.doze_clk_en
      && cfg_q.rate_sel >= `TPC_RATE_SEL_DOZE_MAX);
    div_d = div_q + 10'h001;
    host_clock_out_d = host_clock_out_q;
    if (!host_clock_out_run) begin
      div_d = 10'h000;
      host_clock_out_d = 1'b0;
    end else if (div_d >= half_cycles(cfg_q.rate_sel)) begin
      div_d = 10'h000;
      host_clock_out_d = ~host_clock_out_q;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 10'h000;
      host_clock_out_q <= 1'b0;
    end else begin
      div_q <= div_d;
      host_clock_out_q <= host_clock_out_d;
    end
  end
  assign host_clock_out = host_clock_out_q;
  assign host_clock_oe = !off;

  // interrupt: pending flag, set wins over ack, short release before re-assert
  logic irq_pend_q, irq_pend_d, irq_pin_q, irq_pin_d;
  logic [1:0] gap_q, gap_d;
  always_comb begin
    irq_pend_d = irq_pend_q;
    gap_d = gap_q;
    if (irq_ack) begin
      irq_pend_d = 1'b0;
      gap_d = 2'(`TPC_IRQ_GAP_CYC);
    end else if (gap_q != 2'h0) begin
      gap_d = gap_q - 2'h1;
    end
    if (irq_event && !off) begin
      irq_pend_d = 1'b1;
    end
    irq_pin_d = irq_pend_q && gap_q == 2'h0 && !irq_ack;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_pend_q <= 1'b0;
      irq_pin_q <= 1'b0;
      gap_q <= 2'h0;
    end else begin
      irq_pend_q <= irq_pend_d;
      irq_pin_q <= irq_pin_d;
      gap_q <= gap_d;
    end
  end
  assign irq_n_o = 1'b0;
  assign irq_n_oe = irq_pin_q;
  assign irq_pullup_en = cfg_q.pullup_en && !off;

  // serial port slave; not functional in off, hibernate or doze
  logic spi_live;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic hdr_q, hdr_d, miso_q, miso_d, valid_d;
  tpc_pins_pkg::tpc_spi_word_type word_d;
  always_comb begin
    spi_live = cs_s && (mode_q == tpc_pins_pkg::TPC_IDLE || mode_q == tpc_pins_pkg::TPC_RX
      || mode_q == tpc_pins_pkg::TPC_TX);
    bit_d = bit_q;
    sh_d = sh_q;
    tx_d = tx_q;
    hdr_d = hdr_q;
    miso_d = miso_q;
    word_d = spi_word_q;
    valid_d = 1'b0;
    if (!spi_live) begin
      bit_d = 3'h0;
      hdr_d = 1'b1;
      tx_d = 8'h00;
      miso_d = 1'b0;
    end else if (sclk_rise) begin
      sh_d = {sh_q[6:0], mosi_s};
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        valid_d = 1'b1;
        if (hdr_q) begin
          hdr_d = 1'b0;
          word_d.rd = sh_d[`TPC_HDR_RW_BIT];
          word_d.addr = sh_d[`TPC_HDR_ADDR_MSB:0];
          word_d.data = 8'h00;
        end else begin
          word_d.data = spi_word_q.rd ? tx_q : sh_d;
        end
        tx_d = spi_rd_byte;
      end
    end else if (sclk_fall) begin
      miso_d = tx_q[7];
      tx_d = {tx_q[6:0], 1'b0};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      hdr_q <= 1'b1;
      miso_q <= 1'b0;
      spi_word_q <= '0;
      spi_valid <= 1'b0;
    end else begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      hdr_q <= hdr_d;
      miso_q <= miso_d;
      spi_word_q <= word_d;
      spi_valid <= valid_d;
    end
  end
  assign miso_o = cs_s ? miso_q : 1'b0;
  assign miso_oe = !off && (cs_s || !cfg_q.miso_hiz_en);

  // aux pins
  logic [6:0] aux_d;
  always_comb begin
    aux_pin_o = cfg_q.aux_out;
    aux_pin_oe = off ? 7'h00 : cfg_q.aux_dir;
    if (cfg_q.alt_en && !off) begin
      aux_pin_o[0] = mode_q != tpc_pins_pkg::TPC_IDLE;
      aux_pin_oe[0] = 1'b1;
      aux_pin_o[1] = crc_q;
      aux_pin_oe[1] = 1'b1;
    end
    aux_d = sync2_q[12:6];
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aux_in_q <= 7'h00;
    end else begin
      aux_in_q <= aux_d;
    end
  end

  // checks
  sequence s_trig_rise;
    trig_s && !trig_prev_q && mode_q == tpc_pins_pkg::TPC_IDLE && rst_pin_s;
  endsequence
  sequence s_seq_active;
    mode_q == tpc_pins_pkg::TPC_RX || mode_q == tpc_pins_pkg::TPC_TX;
  endsequence

  chk_seq_start: assert property (@(posedge sys_clk) disable iff (rst)
    s_trig_rise |=> s_seq_active)
    else $error("trigger rise did not start a sequence");
  chk_seq_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (s_seq_active ##0 (!trig_s && rst_pin_s)) |=> mode_q == tpc_pins_pkg::TPC_IDLE)
    else $error("trigger low did not force idle");
  chk_off_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !rst_pin_s [*2] |-> off && cfg_q == CFG_RST && aux_pin_oe == 7'h00)
    else $error("reset pin low did not hold off mode");
  chk_reset_idle: assert property (@(posedge sys_clk) disable iff (rst)
    off && rst_pin_s |=> mode_q == tpc_pins_pkg::TPC_IDLE && cfg_q.rate_sel == `TPC_RATE_SEL_RST)
    else $error("release did not enter idle with defaults");
  chk_wake_idle: assert property (@(posedge sys_clk) disable iff (rst)
    (mode_q == tpc_pins_pkg::TPC_DOZE || mode_q == tpc_pins_pkg::TPC_HIBERNATE)
    && !wake_s && rst_pin_s |=> mode_q == tpc_pins_pkg::TPC_IDLE)
    else $error("wake did not return to idle");
  chk_alt_pins: assert property (@(posedge sys_clk) disable iff (rst)
    cfg_q.alt_en && !off |-> aux_pin_oe[1:0] == 2'b11 && aux_pin_o[1] == crc_q
    && aux_pin_o[0] == (mode_q != tpc_pins_pkg::TPC_IDLE))
    else $error("indicator pins wrong");
  chk_plain_pins: assert property (@(posedge sys_clk) disable iff (rst)
    !cfg_q.alt_en && !off |-> aux_pin_oe == cfg_q.aux_dir && aux_pin_o == cfg_q.aux_out)
    else $error("aux pins not plain");
  chk_miso_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !cs_s && !off |-> miso_oe == !cfg_q.miso_hiz_en && miso_o == 1'b0)
    else $error("serial output wrong while deselected");
  chk_no_cs_xfer: assert property (@(posedge sys_clk) disable iff (rst)
    !cs_s |=> !spi_valid && bit_q == 3'h0)
    else $error("transfer accepted without chip select");
  chk_irq_fast: assert property (@(posedge sys_clk) disable iff (rst)
    irq_event && !off && !irq_ack && gap_q == 2'h0 |=> ##1 irq_n_oe)
    else $error("interrupt not asserted in time");
  chk_miso_fall: assert property (@(posedge sys_clk) disable iff (rst)
    spi_live && !sclk_fall && !sclk_rise |=> miso_q == $past(miso_q))
    else $error("serial output changed off the falling edge");

endmodule // tpc_pin_ctrl
`default_nettype wire

// [test/tpc_host_model.sv]
// Purpose: host side of the serial port, framing and shifting bytes
// Assumes: serial clock half period of four system clock cycles
// Notes: a released data line reads unknown so a floating pin never matches
`timescale 1ns/1ps
`default_nettype none
module tpc_host_model (
  input wire logic sys_clk,
  input wire logic miso_o,
  input wire logic miso_oe,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // msb first; data changes with the falling clock, taken as it rises
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge sys_clk);
      rx[i] = miso_oe ? miso_o : 1'bx;
      sclk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] hdr, input logic [7:0] dat, input logic sel,
                       output logic [7:0] rx);
    logic [7:0] junk;
    @(posedge sys_clk);
    cs_n <= ~sel;
    repeat (4) @(posedge sys_clk);
    xfer(hdr, junk);
    xfer(dat, rx);
    repeat (8) @(posedge sys_clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // tpc_host_model
`default_nettype wire

// [test/transceiver_host_pin_control_tb_top.sv]
// Purpose: self-checking bench of the transceiver host pin logic
// Assumes: 20 MHz system clock, host model on the serial port
// Notes: clock output half periods follow the divider chosen by the design
`timescale 1ns/1ps
`default_nettype none
module transceiver_host_pin_control_tb_top;
  logic sys_clk, rst, reset_pin_n, trig, wake_n, hib, doze, cfg_wr, crc_valid;
  logic irq_event, irq_ack, irq_n_o, irq_n_oe, irq_pullup_en, host_clock_out, host_clock_oe;
  logic sclk, cs_n, mosi, miso_o, miso_oe, spi_valid;
  logic [7:0] spi_rd_byte, rx;
  logic [6:0] aux_pin_i, aux_pin_o, aux_pin_oe, aux_in_q;
  tpc_pins_pkg::tpc_cfg_type cfg_in, cfg_q, c;
  tpc_pins_pkg::tpc_mode_type mode_q;
  tpc_pins_pkg::tpc_spi_word_type spi_word_q;
  tpc_pins_pkg::tpc_spi_word_type q[$];
  int err_total, cmp_count;
  // rate 6, pull-up on, float on, all aux pins inputs
  localparam tpc_pins_pkg::tpc_cfg_type def_cfg = 22'h1b_0000;
  localparam int hp[8] = '{1, 1, 2, 5, 10, 160, 305, 610};

  tpc_pin_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .radio_sequence_trigger(trig), .wake_request_n(wake_n), .hibernate_req(hib),
    .doze_req(doze), .cfg_wr(cfg_wr), .cfg_in(cfg_in), .cfg_q(cfg_q), .mode_q(mode_q),
    .crc_valid(crc_valid), .irq_event(irq_event), .irq_ack(irq_ack), .irq_n_o(irq_n_o),
    .irq_n_oe(irq_n_oe), .irq_pullup_en(irq_pullup_en), .host_clock_out(host_clock_out),
    .host_clock_oe(host_clock_oe), .serial_clock_in(sclk), .chip_select_n(cs_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .spi_valid(spi_valid),
    .spi_word_q(spi_word_q), .spi_rd_byte(spi_rd_byte), .aux_pin_i(aux_pin_i),
    .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe), .aux_in_q(aux_in_q));

  tpc_host_model host (.sys_clk(sys_clk), .miso_o(miso_o), .miso_oe(miso_oe),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (spi_valid === 1'b1) q.push_back(spi_word_q);
  end

  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wm(input tpc_pins_pkg::tpc_mode_type m, input string s);
    for (int i = 0; i < 20 && mode_q !== m; i++) @(negedge sys_clk);
    chk(mode_q, m, s);
  endtask

  task automatic wcfg(input tpc_pins_pkg::tpc_cfg_type v);
    @(posedge sys_clk);
    cfg_in <= v;
    cfg_wr <= 1'b1;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    @(negedge sys_clk);
  endtask

  // high time of the clock output in system cycles, bounded wait
  task automatic meas(input int exp);
    int n, st;
    n = 0;
    st = 0;
    for (int i = 0; i < 3000 && st < 3; i++) begin
      @(negedge sys_clk);
      if (st == 0 && host_clock_out === 1'b0) st = 1;
      else if (st == 1 && host_clock_out === 1'b1) st = 2;
      if (st == 2) begin
        if (host_clock_out === 1'b0) st = 3;
        else n++;
      end
    end
    chk(n, exp, "clock half period");
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    results();
  end

  initial begin
    rst = 1'b1; reset_pin_n = 1'b1; trig = 1'b0; wake_n = 1'b1; hib = 1'b0; doze = 1'b0;
    cfg_wr = 1'b0; cfg_in = def_cfg; crc_valid = 1'b0; irq_event = 1'b0; irq_ack = 1'b0;
    spi_rd_byte = 8'h00; aux_pin_i = 7'h00; err_total = 0; cmp_count = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    wm(tpc_pins_pkg::TPC_IDLE, "idle after reset");
    chk(cfg_q, def_cfg, "settings default");
    chk(aux_pin_oe, 7'h00, "aux pins inputs");
    chk(miso_oe, 1'b0, "miso floats deselected");
    meas(hp[6]);
    $display("test reset done");
    for (int s = 0; s < 8; s++) begin
      c = def_cfg;
      c.rate_sel = s[2:0];
      wcfg(c);
      meas(hp[s]);
    end
    chk(host_clock_oe, 1'b1, "clock output driven");
    $display("test clock rates done");
    c = def_cfg;
    c.miso_hiz_en = 1'b0;
    wcfg(c);
    chk(miso_oe, 1'b1, "miso driven deselected");
    chk(miso_o, 1'b0, "miso low deselected");
    host.frame(8'h05, 8'ha5, 1'b1, rx);
    chk(q.size(), 2, "write byte count");
    chk(q[0], {1'b0, 6'h05, 8'h00}, "write header");
    chk(q[1], {1'b0, 6'h05, 8'ha5}, "write data");
    q.delete();
    @(posedge sys_clk);
    spi_rd_byte <= 8'h3c;
    host.frame(8'h83, 8'h00, 1'b1, rx);
    chk(rx, 8'h3c, "read data on miso");
    chk(q.size(), 2, "read byte count");
    chk(q[0], {1'b1, 6'h03, 8'h00}, "read header");
    q.delete();
    host.frame(8'h05, 8'h11, 1'b0, rx);
    chk(q.size(), 0, "deselected bits ignored");
    $display("test serial done");
    c = def_cfg;
    c.aux_dir = 7'h7f;
    c.aux_out = 7'h55;
    wcfg(c);
    chk(aux_pin_oe, 7'h7f, "aux directions");
    chk(aux_pin_o, 7'h55, "aux outputs plain");
    @(posedge sys_clk);
    aux_pin_i <= 7'h2a;
    repeat (4) @(negedge sys_clk);
    chk(aux_in_q, 7'h2a, "aux inputs read");
    c.alt_en = 1'b1;
    wcfg(c);
    chk(aux_pin_o[0], 1'b0, "in idle indication");
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk);
      crc_valid <= v[0];
      repeat (3) @(negedge sys_clk);
      chk(aux_pin_o[1], v[0], "checksum indication");
    end
    for (int t = 0; t < 2; t++) begin
      c.seq_tx = t[0];
      wcfg(c);
      @(posedge sys_clk);
      trig <= 1'b1;
      wm(t ? tpc_pins_pkg::TPC_TX : tpc_pins_pkg::TPC_RX, "sequence start");
      chk(aux_pin_o[0], 1'b1, "out of idle indication");
      @(posedge sys_clk);
      trig <= 1'b0;
      wm(tpc_pins_pkg::TPC_IDLE, "trigger low idle");
      repeat (4) @(posedge sys_clk);
    end
    $display("test sequence done");
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      hib <= (k == 0);
      doze <= (k == 1);
      @(posedge sys_clk);
      hib <= 1'b0;
      doze <= 1'b0;
      wm(k ? tpc_pins_pkg::TPC_DOZE : tpc_pins_pkg::TPC_HIBERNATE, "low power");
      @(posedge sys_clk);
      wake_n <= 1'b0;
      wm(tpc_pins_pkg::TPC_IDLE, "wake to idle");
      @(posedge sys_clk);
      wake_n <= 1'b1;
    end
    $display("test wake done");
    chk(irq_pullup_en, 1'b1, "pull-up on");
    for (int r = 0; r < 3; r++) begin
      @(posedge sys_clk);
      irq_event <= 1'b1;
      @(posedge sys_clk);
      irq_event <= 1'b0;
      for (int i = 0; i < 120 && irq_n_oe !== 1'b1; i++) @(negedge sys_clk);
      chk(irq_n_oe, 1'b1, "interrupt asserted in time");
      chk(irq_n_o, 1'b0, "open drain low");
      @(posedge sys_clk);
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
      for (int i = 0; i < 120 && irq_n_oe !== 1'b0; i++) @(negedge sys_clk);
      chk(irq_n_oe, 1'b0, "interrupt released");
    end
    c.pullup_en = 1'b0;
    wcfg(c);
    chk(irq_pullup_en, 1'b0, "pull-up off");
    $display("test interrupt done");
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    wm(tpc_pins_pkg::TPC_OFF, "reset pin off");
    chk(cfg_q, def_cfg, "settings lost");
    @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    wm(tpc_pins_pkg::TPC_IDLE, "reset pin released");
    chk(aux_pin_oe, 7'h00, "aux inputs again");
    $display("test reset pin done");
    results();
  end
endmodule // transceiver_host_pin_control_tb_top
`default_nettype wire
